// file: src/mtp_access_map.svh
// constants shared by both ends of the memory access link
// How it works
// [RULE1] command 0x10 plus two address bytes
// [RULE2] command 0x12 plus one byte programs memory
// [RULE3] command 0x14 then one byte read back
// [RULE4] master sets address before write or read
// [RULE5] address command ack shows idle, nak busy
// [RULE6] busy memory naks command and data phases
// [RULE7] address register loads only while memory idle
// [RULE8] programming starts after command and one byte
// [RULE9] no programming unless both phases acked
// [RULE10] master reads back written byte to verify
// [RULE11] read command acked only when serviceable
// [RULE12] master may abandon naked read and retry
// [RULE13] writes to words 0x40-0x4e are rejected
// [RULE14] user words 0x12-0x3e, 0x80-0x3ff free
// [RULE15] config words 0x00-0x10, 0x50-0x7e checksummed
// [RULE16] master rewrites checksum before any reset
// [RULE17] bad checksum at start disables the link
// [RULE18] only the usb side can recover checksum
// [RULE19] memory scanned after power-on or usb reset
// [RULE20] address bytes sent high byte first
// [RULE21] busy from program start until it completes
`ifndef MTP_ACCESS_MAP_SVH
`define MTP_ACCESS_MAP_SVH
`define MTP_CMD_SET_ADDR 8'h10
`define MTP_CMD_WRITE 8'h12
`define MTP_CMD_READ 8'h14
`define MTP_CFG_A_LO 10'h000
`define MTP_CFG_A_HI 10'h010
`define MTP_USR1_LO 10'h012
`define MTP_USR1_HI 10'h03e
`define MTP_RSV_LO 10'h040
`define MTP_RSV_HI 10'h04e
`define MTP_CFG_B_LO 10'h050
`define MTP_CFG_B_HI 10'h07e
`define MTP_CKSUM_WADDR 10'h07f
`define MTP_USR2_LO 10'h080
`define MTP_USR2_HI 10'h3ff
`define MTP_WORDS 1024
`define MTP_TOP_BYTE 16'h07ff
`define MTP_CLK_MHZ 40
`define MTP_PROG_TIME_NS 100000
`define MTP_PROG_CYCLES ((`MTP_PROG_TIME_NS * `MTP_CLK_MHZ + 999) / 1000)
`define MTP_RETRY_MAX 4'h3
`define MTP_PHASE_LAST 2'h3
`endif

// file: src/mtp_pkg.sv
// types shared by both ends of the memory access link
package mtp_pkg;
  typedef enum logic [1:0] {
    DS_SCAN = 2'b00,
    DS_RUN = 2'b01,
    DS_DISABLED = 2'b10
  } dev_state_e;

  typedef enum logic [1:0] {
    OP_SET_ADDR = 2'b00,
    OP_WRITE = 2'b01,
    OP_READ = 2'b10
  } host_op_e;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_ISSUE = 2'b01,
    HS_WAIT = 2'b10,
    HS_STOP = 2'b11
  } host_state_e;

  typedef enum logic [2:0] {
    ST_ADDR_CMD = 3'b000,
    ST_ADDR_HI = 3'b001,
    ST_ADDR_LO = 3'b010,
    ST_OP_CMD = 3'b011,
    ST_WR_DATA = 3'b100,
    ST_RD_DATA = 3'b101
  } host_step_e;
endpackage

// file: src/mtp_link_if.sv
// byte-level general-call link between master and memory device
interface mtp_link_if;
  logic req;
  logic first;
  logic rd_phase;
  logic stop;
  logic [7:0] wdata;
  logic ack_vld;
  logic ack;
  logic [7:0] rdata;

  modport host (output req, output first, output rd_phase, output stop, output wdata,
                input ack_vld, input ack, input rdata);
  modport dev (input req, input first, input rd_phase, input stop, input wdata,
               output ack_vld, output ack, output rdata);
endinterface

// file: src/mtp_cell_array.sv
// word array with a timed byte-program operation
`include "mtp_access_map.svh"
module mtp_cell_array #(
  parameter int WORDS = `MTP_WORDS,
  parameter int PROG_CYCLES = `MTP_PROG_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // program request
  input wire logic prog_start,
  input wire logic [9:0] prog_waddr,
  input wire logic prog_lane,
  input wire logic [7:0] prog_byte,
  output logic busy,
  // read port
  input wire logic [9:0] rd_waddr,
  output logic [15:0] rd_word
);
  logic [15:0] mem [WORDS];
  logic [31:0] cnt_q;
  logic [9:0] wa_q;
  logic lane_q;
  logic [7:0] wb_q;

  // blank part holds all zero, a valid checksum
  initial begin
    for (int i = 0; i < WORDS; i++) begin
      mem[i] = 16'h0000;
    end
  end

  // program timer, busy for the whole operation
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      busy <= 1'b0;
      cnt_q <= 32'h0;
      wa_q <= 10'h000;
      lane_q <= 1'b0;
      wb_q <= 8'h00;
    end else if (!busy && prog_start) begin
      busy <= 1'b1; // RULE21
      cnt_q <= 32'(PROG_CYCLES);
      wa_q <= prog_waddr;
      lane_q <= prog_lane;
      wb_q <= prog_byte;
    end else if (busy) begin
      cnt_q <= cnt_q - 32'h1;
      if (cnt_q == 32'h1) begin
        busy <= 1'b0;
      end
    end
  end

  // byte lands at the end of the program time
  always_ff @(posedge clk_sys) begin
    if (busy && cnt_q == 32'h1) begin
      if (lane_q) begin
        mem[wa_q][15:8] <= wb_q;
      end else begin
        mem[wa_q][7:0] <= wb_q;
      end
    end
  end

  assign rd_word = mem[rd_waddr];
endmodule // mtp_cell_array

// file: src/mtp_dev_end.sv
// memory access command handler inside the general-call slave
`include "mtp_access_map.svh"
module mtp_dev_end #(
  parameter int PROG_CYCLES = `MTP_PROG_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // link to the master
  mtp_link_if.dev link,
  // usb side
  input wire logic usb_reset,
  input wire logic usb_wr_en,
  input wire logic [15:0] usb_wr_addr,
  input wire logic [7:0] usb_wr_data,
  // status
  output logic cfg_valid,
  output logic if_disabled,
  output logic mem_busy
);
  mtp_pkg::dev_state_e state_q;
  logic [9:0] scan_idx_q;
  logic [15:0] sum_q;
  logic [15:0] addr_q;
  logic [7:0] addr_hi_q;
  logic [7:0] cmd_q;
  logic cmd_ack_q;
  logic [1:0] phase_q;
  logic [7:0] rbyte_q;
  logic ack_vld_q;
  logic ack_q;
  logic store_busy;
  logic [9:0] rd_waddr;
  logic [15:0] rd_word;
  logic [7:0] rd_byte;
  logic busy;
  logic idle;
  logic addr_ok;
  logic ack_d;
  logic prog_go;
  logic usb_go;
  logic commit;
  logic prog_start;
  logic [9:0] prog_waddr;
  logic prog_lane;
  logic [7:0] prog_byte;

  // words counted into the configuration checksum
  function automatic logic covered(input logic [9:0] w);
    covered = (w <= `MTP_CFG_A_HI) || (w >= `MTP_CFG_B_LO && w <= `MTP_CFG_B_HI); // RULE15
  endfunction

  // words the link may program
  function automatic logic writable(input logic [9:0] w);
    logic rsv;
    logic usr;
    rsv = (w >= `MTP_RSV_LO) && (w <= `MTP_RSV_HI); // RULE13
    usr = (w >= `MTP_USR1_LO && w <= `MTP_USR1_HI) || (w >= `MTP_USR2_LO); // RULE14
    writable = !rsv || usr;
  endfunction

  mtp_cell_array #(
    .WORDS(`MTP_WORDS),
    .PROG_CYCLES(PROG_CYCLES)
  ) u_cells (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .prog_start(prog_start),
    .prog_waddr(prog_waddr),
    .prog_lane(prog_lane),
    .prog_byte(prog_byte),
    .busy(store_busy),
    .rd_waddr(rd_waddr),
    .rd_word(rd_word)
  );

  // read port follows the scan or the address register
  assign rd_waddr = (state_q == mtp_pkg::DS_SCAN) ? scan_idx_q : addr_q[10:1];
  assign rd_byte = addr_q[0] ? rd_word[15:8] : rd_word[7:0];
  assign busy = store_busy || (state_q == mtp_pkg::DS_SCAN);
  assign idle = (state_q == mtp_pkg::DS_RUN) && !busy;
  assign addr_ok = addr_q <= `MTP_TOP_BYTE;

  // usb programming path, also the only checksum repair route
  assign usb_go = usb_wr_en && !busy && (state_q != mtp_pkg::DS_SCAN)
                  && (usb_wr_addr <= `MTP_TOP_BYTE); // RULE18

  // answer to the byte offered this cycle
  always_comb begin
    ack_d = 1'b0;
    prog_go = 1'b0;
    commit = 1'b0;
    if (link.req && !usb_go) begin
      if (link.first) begin
        case (link.wdata)
          `MTP_CMD_SET_ADDR: ack_d = idle; // RULE5
          `MTP_CMD_WRITE: ack_d = idle && addr_ok; // RULE6
          `MTP_CMD_READ: ack_d = idle && addr_ok; // RULE11
          default: ack_d = 1'b0;
        endcase
      end else begin
        case (cmd_q)
          `MTP_CMD_SET_ADDR: begin
            ack_d = cmd_ack_q && idle && (phase_q < 2'h2); // RULE1
            commit = ack_d && (phase_q == 2'h1); // RULE7
          end
          `MTP_CMD_WRITE: begin
            ack_d = cmd_ack_q && idle && (phase_q == 2'h0) && writable(addr_q[10:1]); // RULE9
            prog_go = ack_d; // RULE8
          end
          `MTP_CMD_READ: ack_d = cmd_ack_q && idle && link.rd_phase && (phase_q == 2'h0); // RULE3
          default: ack_d = 1'b0;
        endcase
      end
    end
  end

  // program request into the array, usb first
  assign prog_start = usb_go || prog_go; // RULE2
  assign prog_waddr = usb_go ? usb_wr_addr[10:1] : addr_q[10:1];
  assign prog_lane = usb_go ? usb_wr_addr[0] : addr_q[0];
  assign prog_byte = usb_go ? usb_wr_data : link.wdata;

  // startup scan and checksum check
  always_ff @(posedge clk_sys) begin
    if (!rst_n || usb_reset) begin
      state_q <= mtp_pkg::DS_SCAN; // RULE19
      scan_idx_q <= 10'h000;
      sum_q <= 16'h0000;
    end else if (state_q == mtp_pkg::DS_SCAN) begin
      if (scan_idx_q == `MTP_CKSUM_WADDR) begin
        state_q <= (sum_q == rd_word) ? mtp_pkg::DS_RUN : mtp_pkg::DS_DISABLED; // RULE17
      end else begin
        if (covered(scan_idx_q)) begin
          sum_q <= sum_q + rd_word;
        end
        scan_idx_q <= scan_idx_q + 10'h001;
      end
    end
  end

  // command tracking across the phases of one general call
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cmd_q <= 8'h00;
      cmd_ack_q <= 1'b0;
      phase_q <= 2'h0;
    end else if (link.req && link.first) begin
      cmd_q <= link.wdata;
      cmd_ack_q <= ack_d;
      phase_q <= 2'h0;
    end else if (link.req) begin
      if (phase_q != `MTP_PHASE_LAST) begin
        phase_q <= phase_q + 2'h1;
      end
    end else if (link.stop) begin
      cmd_ack_q <= 1'b0;
    end
  end

  // address register, high byte first
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      addr_hi_q <= 8'h00;
      addr_q <= 16'h0000;
    end else if (link.req && !link.first && cmd_q == `MTP_CMD_SET_ADDR) begin
      if (phase_q == 2'h0) begin
        addr_hi_q <= link.wdata; // RULE20
      end
      if (commit) begin
        addr_q <= {addr_hi_q, link.wdata}; // RULE7
      end
    end
  end

  // link answer one cycle after each byte
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ack_vld_q <= 1'b0;
      ack_q <= 1'b0;
      rbyte_q <= 8'h00;
    end else begin
      ack_vld_q <= link.req;
      ack_q <= ack_d;
      if (link.req && link.first && link.wdata == `MTP_CMD_READ && ack_d) begin
        rbyte_q <= rd_byte; // RULE3
      end
    end
  end

  // status flags
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_valid <= 1'b0;
      if_disabled <= 1'b0;
      mem_busy <= 1'b1;
    end else begin
      cfg_valid <= state_q == mtp_pkg::DS_RUN;
      if_disabled <= state_q == mtp_pkg::DS_DISABLED; // RULE17
      mem_busy <= busy; // RULE21
    end
  end

  assign link.ack_vld = ack_vld_q;
  assign link.ack = ack_q;
  assign link.rdata = rbyte_q;
endmodule // mtp_dev_end

// file: src/mtp_host_end.sv
// general-call master that sets the address, writes and reads memory bytes
`include "mtp_access_map.svh"
module mtp_host_end #(
  parameter logic [3:0] RETRY_MAX = `MTP_RETRY_MAX
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // link to the device
  mtp_link_if.host link,
  // user request
  input wire logic op_valid,
  input wire logic [1:0] op_kind,
  input wire logic [15:0] op_addr,
  input wire logic [7:0] op_wdata,
  input wire logic op_verify,
  output logic op_ready,
  // user result
  output logic done,
  output logic done_ok,
  output logic [7:0] done_rdata
);
  mtp_pkg::host_state_e hs_q;
  mtp_pkg::host_step_e step_q;
  mtp_pkg::host_step_e nstep_q;
  mtp_pkg::host_op_e kind_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q;
  logic verify_q;
  logic checking_q;
  logic fin_q;
  logic ok_q;
  logic [3:0] retry_q;
  logic req_q;
  logic first_q;
  logic rdph_q;
  logic stop_q;
  logic [7:0] byte_q;

  // byte sent in each step
  function automatic logic [7:0] step_byte(input mtp_pkg::host_step_e s, input mtp_pkg::host_op_e k,
                                           input logic [15:0] a, input logic [7:0] d);
    case (s)
      mtp_pkg::ST_ADDR_CMD: step_byte = `MTP_CMD_SET_ADDR;
      mtp_pkg::ST_ADDR_HI: step_byte = a[15:8]; // RULE20
      mtp_pkg::ST_ADDR_LO: step_byte = a[7:0];
      mtp_pkg::ST_OP_CMD: step_byte = (k == mtp_pkg::OP_WRITE) ? `MTP_CMD_WRITE : `MTP_CMD_READ;
      mtp_pkg::ST_WR_DATA: step_byte = d;
      default: step_byte = 8'hff;
    endcase
  endfunction

  // sequencer: address call, then the operation call
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hs_q <= mtp_pkg::HS_IDLE;
      step_q <= mtp_pkg::ST_ADDR_CMD;
      nstep_q <= mtp_pkg::ST_ADDR_CMD;
      kind_q <= mtp_pkg::OP_SET_ADDR;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      verify_q <= 1'b0;
      checking_q <= 1'b0;
      fin_q <= 1'b0;
      ok_q <= 1'b0;
      retry_q <= 4'h0;
      done_rdata <= 8'h00;
    end else begin
      case (hs_q)
        mtp_pkg::HS_IDLE: begin
          if (op_valid) begin
            kind_q <= mtp_pkg::host_op_e'(op_kind);
            addr_q <= op_addr;
            wdata_q <= op_wdata;
            verify_q <= op_verify;
            checking_q <= 1'b0;
            retry_q <= 4'h0;
            step_q <= mtp_pkg::ST_ADDR_CMD; // RULE4
            hs_q <= mtp_pkg::HS_ISSUE;
          end
        end
        mtp_pkg::HS_ISSUE: hs_q <= mtp_pkg::HS_WAIT;
        mtp_pkg::HS_WAIT: begin
          if (link.ack_vld) begin
            hs_q <= mtp_pkg::HS_STOP;
            fin_q <= 1'b1;
            ok_q <= 1'b0;
            if (link.ack) begin
              case (step_q)
                mtp_pkg::ST_ADDR_CMD: begin
                  step_q <= mtp_pkg::ST_ADDR_HI;
                  hs_q <= mtp_pkg::HS_ISSUE;
                end
                mtp_pkg::ST_ADDR_HI: begin
                  step_q <= mtp_pkg::ST_ADDR_LO;
                  hs_q <= mtp_pkg::HS_ISSUE;
                end
                mtp_pkg::ST_ADDR_LO: begin
                  fin_q <= kind_q == mtp_pkg::OP_SET_ADDR;
                  ok_q <= 1'b1;
                  nstep_q <= mtp_pkg::ST_OP_CMD;
                end
                mtp_pkg::ST_OP_CMD: begin
                  step_q <= (kind_q == mtp_pkg::OP_WRITE) ? mtp_pkg::ST_WR_DATA : mtp_pkg::ST_RD_DATA;
                  hs_q <= mtp_pkg::HS_ISSUE;
                end
                mtp_pkg::ST_WR_DATA: begin
                  ok_q <= 1'b1;
                  fin_q <= !verify_q;
                  checking_q <= verify_q; // RULE10
                  kind_q <= verify_q ? mtp_pkg::OP_READ : kind_q;
                  nstep_q <= mtp_pkg::ST_ADDR_CMD;
                end
                default: begin
                  done_rdata <= link.rdata;
                  ok_q <= checking_q ? (link.rdata == wdata_q) : 1'b1; // RULE10
                end
              endcase
            end else if (step_q == mtp_pkg::ST_ADDR_CMD && checking_q) begin
              // poll the address call until the program just started ends
              fin_q <= 1'b0; // RULE5
              nstep_q <= mtp_pkg::ST_ADDR_CMD; // RULE10
            end else if (step_q == mtp_pkg::ST_RD_DATA && retry_q != RETRY_MAX) begin
              retry_q <= retry_q + 4'h1; // RULE12
              fin_q <= 1'b0;
              nstep_q <= mtp_pkg::ST_OP_CMD;
            end
          end
        end
        mtp_pkg::HS_STOP: begin
          step_q <= nstep_q;
          hs_q <= fin_q ? mtp_pkg::HS_IDLE : mtp_pkg::HS_ISSUE;
        end
        default: hs_q <= mtp_pkg::HS_IDLE;
      endcase
    end
  end

  // link drive, one request pulse per byte
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      req_q <= 1'b0;
      first_q <= 1'b0;
      rdph_q <= 1'b0;
      stop_q <= 1'b0;
      byte_q <= 8'h00;
    end else begin
      req_q <= hs_q == mtp_pkg::HS_ISSUE;
      stop_q <= (hs_q == mtp_pkg::HS_WAIT) && link.ack_vld && !(link.ack
                && (step_q == mtp_pkg::ST_ADDR_CMD || step_q == mtp_pkg::ST_ADDR_HI
                || step_q == mtp_pkg::ST_OP_CMD));
      if (hs_q == mtp_pkg::HS_ISSUE) begin
        first_q <= step_q == mtp_pkg::ST_ADDR_CMD || step_q == mtp_pkg::ST_OP_CMD; // RULE1
        rdph_q <= step_q == mtp_pkg::ST_RD_DATA;
        byte_q <= step_byte(step_q, kind_q, addr_q, wdata_q);
      end
    end
  end

  // user handshake
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      op_ready <= 1'b0;
      done <= 1'b0;
      done_ok <= 1'b0;
    end else begin
      op_ready <= (hs_q == mtp_pkg::HS_IDLE) && !op_valid;
      done <= (hs_q == mtp_pkg::HS_STOP) && fin_q;
      if ((hs_q == mtp_pkg::HS_STOP) && fin_q) begin
        done_ok <= ok_q;
      end
    end
  end

  assign link.req = req_q;
  assign link.first = first_q;
  assign link.rd_phase = rdph_q;
  assign link.stop = stop_q;
  assign link.wdata = byte_q;
endmodule // mtp_host_end

// file: dv/mtp_link_asserts.sv
// link checker for the memory access general-call exchange
module mtp_link_asserts #(
  parameter int PROG_CYCLES = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // link signals
  input wire logic req,
  input wire logic first,
  input wire logic rd_phase,
  input wire logic stop,
  input wire logic [7:0] wdata,
  input wire logic ack_vld,
  input wire logic ack,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cmd_q;
  logic [1:0] idx_q;
  logic [7:0] hi_q;
  logic [7:0] lo_q;
  logic [15:0] addr_q;
  logic cmd_ok_q;
  logic wr_pend_q;
  logic [15:0] busy_cnt_q;
  logic [7:0] scan_cnt_q;
  logic wr_byte;
  logic rsv_hit;

  // write data byte of a write call, and reserved word hit
  assign wr_byte = req && !first && cmd_q == 8'h12 && idx_q == 2'h1;
  assign rsv_hit = addr_q[10:1] >= 10'h040 && addr_q[10:1] <= 10'h04e;

  // command and byte position of the current call
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cmd_q <= 8'h00;
      idx_q <= 2'h0;
    end else if (req && first) begin
      cmd_q <= wdata;
      idx_q <= 2'h1;
    end else if (req && idx_q != 2'h3) begin
      idx_q <= idx_q + 2'h1;
    end
  end

  // command phase outcome
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cmd_ok_q <= 1'b0;
    end else if (ack_vld && idx_q == 2'h1) begin
      cmd_ok_q <= ack;
    end
  end

  // address model, loaded only when the low byte is acked
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hi_q <= 8'h00;
      lo_q <= 8'h00;
      addr_q <= 16'h0000;
    end else if (req && !first && cmd_q == 8'h10) begin
      if (idx_q == 2'h1) begin
        hi_q <= wdata;
      end else begin
        lo_q <= wdata;
      end
    end else if (ack_vld && ack && cmd_q == 8'h10 && idx_q == 2'h3) begin
      addr_q <= {hi_q, lo_q};
    end
  end

  // program timer started by an acked write data byte
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      busy_cnt_q <= 16'h0000;
    end else begin
      wr_pend_q <= wr_byte;
      if (ack_vld && ack && wr_pend_q) begin
        busy_cnt_q <= 16'(PROG_CYCLES);
      end else if (busy_cnt_q != 16'h0000) begin
        busy_cnt_q <= busy_cnt_q - 16'h0001;
      end
    end
  end

  // cycles since reset release, saturating
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      scan_cnt_q <= 8'h00;
    end else if (scan_cnt_q != 8'hff) begin
      scan_cnt_q <= scan_cnt_q + 8'h01;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  ack_timing_a: assert property (req |=> ack_vld && !req)
    else $error("byte not answered one cycle later");
  ack_source_a: assert property (ack_vld |-> $past(req))
    else $error("answer without a byte");
  stop_pulse_a: assert property (stop |=> !stop)
    else $error("stop longer than one cycle");
  range_nak_a: assert property (req && first && (wdata == 8'h12 || wdata == 8'h14) && addr_q > 16'h07ff |=> !ack)
    else $error("access beyond memory acked");
  scan_nak_a: assert property (req && scan_cnt_q < 8'h78 |=> !ack)
    else $error("byte acked during scan");
  busy_nak_a: assert property (req && busy_cnt_q > 16'h0002 |=> !ack)
    else $error("byte acked while programming");
  reserved_nak_a: assert property (wr_byte && rsv_hit |=> !ack)
    else $error("reserved word write acked");
  read_ack_a: assert property (req && rd_phase && cmd_q == 8'h14 && cmd_ok_q && busy_cnt_q == 16'h0000 |=> ack)
    else $error("serviceable read data refused");

  // main scenarios
  cover property (wr_byte ##1 ack);
  cover property (req && rd_phase ##1 ack);
  cover property (req && busy_cnt_q > 16'h0002 ##1 !ack);
endmodule // mtp_link_asserts

// file: dv/i2c_mtp_memory_access_tb_top.sv
// testbench joining master and device ends of the memory access link
module i2c_mtp_memory_access_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PROG = 8;
  logic clk_sys, rst_n, usb_reset, usb_wr_en, cfg_valid, if_disabled, mem_busy;
  logic [15:0] usb_wr_addr, op_addr;
  logic [7:0] usb_wr_data, op_wdata, done_rdata;
  logic op_valid, op_verify, op_ready, done, done_ok;
  logic [1:0] op_kind;
  int errors, compares, cycles;
  logic [15:0] u_addr [4] = '{16'h0024, 16'h007d, 16'h0100, 16'h07ff};
  logic [7:0] u_data [4] = '{8'ha5, 8'h5a, 8'hc3, 8'h81};

  mtp_link_if link();
  mtp_dev_end #(.PROG_CYCLES(PROG)) i_mtp_dev_end (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
    .usb_reset(usb_reset), .usb_wr_en(usb_wr_en), .usb_wr_addr(usb_wr_addr), .usb_wr_data(usb_wr_data),
    .cfg_valid(cfg_valid), .if_disabled(if_disabled), .mem_busy(mem_busy));
  mtp_host_end i_mtp_host_end (.clk_sys(clk_sys), .rst_n(rst_n), .link(link), .op_valid(op_valid),
    .op_kind(op_kind), .op_addr(op_addr), .op_wdata(op_wdata), .op_verify(op_verify), .op_ready(op_ready),
    .done(done), .done_ok(done_ok), .done_rdata(done_rdata));
  mtp_link_asserts #(.PROG_CYCLES(PROG)) i_mtp_link_asserts (.clk_sys(clk_sys), .rst_n(rst_n),
    .req(link.req), .first(link.first), .rd_phase(link.rd_phase), .stop(link.stop), .wdata(link.wdata),
    .ack_vld(link.ack_vld), .ack(link.ack), .rdata(link.rdata));

  // clock
  initial clk_sys = 1'b0;
  always #12.5 clk_sys = ~clk_sys;

  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // bounded wait on a condition sampled at falling edges
  task automatic wait_for(ref logic sig, input logic lvl);
    int n;
    n = 0;
    while (sig !== lvl && n < 500) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 500) errors++;
  endtask

  task automatic run_op(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d, input logic v);
    wait_for(op_ready, 1'b1);
    op_valid = 1'b1;
    op_kind = k;
    op_addr = a;
    op_wdata = d;
    op_verify = v;
    @(negedge clk_sys);
    op_valid = 1'b0;
    wait_for(done, 1'b1);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic v, input logic ok);
    run_op(2'h1, a, d, v);
    check(16'(done_ok), 16'(ok));
  endtask

  task automatic rd(input logic [15:0] a, input logic ok, input logic [7:0] d);
    run_op(2'h2, a, 8'h00, 1'b0);
    check(16'(done_ok), 16'(ok));
    if (ok) check(16'(done_rdata), 16'(d));
  endtask

  task automatic usb_start(input logic [15:0] a, input logic [7:0] d);
    wait_for(mem_busy, 1'b0);
    usb_wr_en = 1'b1;
    usb_wr_addr = a;
    usb_wr_data = d;
    @(negedge clk_sys);
    usb_wr_en = 1'b0;
  endtask

  // restart the scan by device reset or usb reset, then wait for its verdict
  task automatic restart(input logic by_rst);
    repeat (2) @(negedge clk_sys);
    wait_for(mem_busy, 1'b0); // a device reset would abort a program still running
    if (by_rst) rst_n = 1'b0;
    else usb_reset = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    usb_reset = 1'b0;
    repeat (2) @(negedge clk_sys);
    wait_for(mem_busy, 1'b0);
    repeat (2) @(negedge clk_sys);
  endtask

  // main sequence
  initial begin
    {rst_n, usb_reset, usb_wr_en, op_valid, op_verify} = 5'h00;
    {usb_wr_addr, op_addr} = 32'h0000_0000;
    {usb_wr_data, op_wdata} = 16'h0000;
    op_kind = 2'h0;
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    run_op(2'h0, 16'h0024, 8'h00, 1'b0);
    check(16'(done_ok), 16'h0000);
    wait_for(mem_busy, 1'b0);
    repeat (2) @(negedge clk_sys);
    check(16'({cfg_valid, if_disabled}), 16'h0002);
    run_op(2'h0, 16'h0024, 8'h00, 1'b0);
    check(16'(done_ok), 16'h0001);
    for (int i = 0; i < 4; i++) begin
      wr(u_addr[i], u_data[i], 1'b1, 1'b1);
      rd(u_addr[i], 1'b1, u_data[i]);
    end
    wr(16'h0021, 8'h02, 1'b1, 1'b1);
    wr(16'h00a0, 8'h03, 1'b1, 1'b1);
    wr(16'h00fe, 8'h03, 1'b1, 1'b1);
    wr(16'h00ff, 8'h02, 1'b1, 1'b1);
    wr(16'h0080, 8'h5a, 1'b0, 1'b0);
    wr(16'h009d, 8'h3c, 1'b0, 1'b0);
    rd(16'h0080, 1'b1, 8'h00);
    rd(16'h009d, 1'b1, 8'h00);
    rd(16'h0800, 1'b0, 8'h00);
    // back-to-back writes: the second meets a busy memory
    wr(16'h0102, 8'h66, 1'b0, 1'b1);
    run_op(2'h1, 16'h0104, 8'h77, 1'b0);
    check(16'(done_ok), 16'h0000);
    repeat (20) @(negedge clk_sys);
    rd(16'h0102, 1'b1, 8'h66);
    rd(16'h0104, 1'b1, 8'h00);
    // usb programming keeps the memory busy against the link
    usb_start(16'h0106, 8'h3c);
    run_op(2'h0, 16'h0106, 8'h00, 1'b0);
    check(16'(done_ok), 16'h0000);
    wait_for(mem_busy, 1'b0);
    rd(16'h0106, 1'b1, 8'h3c);
    restart(1'b0);
    check(16'(cfg_valid), 16'h0001);
    // break the checksum, then recover from the usb side only
    usb_start(16'h0000, 8'h01);
    restart(1'b1);
    check(16'(if_disabled), 16'h0001);
    rd(16'h0024, 1'b0, 8'h00);
    wr(16'h00fe, 8'h04, 1'b0, 1'b0);
    restart(1'b0);
    check(16'(if_disabled), 16'h0001);
    usb_start(16'h00fe, 8'h04);
    restart(1'b0);
    check(16'({cfg_valid, if_disabled}), 16'h0002);
    rd(16'h0000, 1'b1, 8'h01);
    complete_run();
  end
endmodule // i2c_mtp_memory_access_tb_top
